// ===== ch2_host_irq_enable.sv
// Channel-2 host interrupt enables with APB register access
//
// Behaviour
// - Bit 3 gates line-eleven request from flag
// - Bit 2 gates line-ten request from flag
// - Bit 1 gates line-nine request from flag
// - Bit 0 gates line-six request from flag
// - Output data write sets the full flag
// - Writing zero clears an enable bit
// - LPC hardware or software reset clears enables
// - Flag clear clears enables outside direct mode
// - Flag set plus enable raises host request
// - Enable sets only by write after read-zero
// - Direct mode requests whenever enable is set
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ns
`include "ch2_irq_cfg.svh"
module ch2_host_irq_enable #(
    parameter int ADDR_W = `CH2_ADDR_W,
    parameter int NUM_EN = 4,
    parameter int NUM_EV = 2
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              host_obf_clear,
    input  wire logic              lpc_hw_reset,
    input  wire logic              lpc_sw_reset,
    output logic                   host_line_eleven_request,
    output logic                   host_line_ten_request,
    output logic                   host_line_nine_request,
    output logic                   host_line_six_request,
    output logic                   ch2_outbuf_full_flag,
    output logic                   irq
);
    ch2_irq_pkg::reg_sel_t sel;

    logic              setup_phase;
    logic              access_phase;
    logic              wr_access;
    logic              rd_access;
    logic              unmapped;
    logic              ctrl_wr;
    logic              ctrl_rd;
    logic              mode_wr;
    logic              odr_wr;
    logic              istat_wr;
    logic              imask_wr;
    logic              lpc_reset;
    logic              obf_fall;
    logic              en_hw_clear;
    logic [NUM_EN-1:0] en;
    logic [NUM_EN-1:0] armed;
    logic [NUM_EN-1:0] req;
    logic [NUM_EV-1:0] events;
    logic [31:0]       rd_mux;

    logic              ch2_direct_mode_ff;
    logic [7:0]        ch2_output_data_reg_ff;
    logic              obf_ff;
    logic              nxt_obf;
    logic [NUM_EV-1:0] istat_ff;
    logic [NUM_EV-1:0] nxt_istat;
    logic [NUM_EV-1:0] imask_ff;
    logic [NUM_EN-1:0] req_ff;
    logic [31:0]       prdata_ff;
    logic              pslverr_ff;

    // Address decode
    assign sel = (paddr == `CH2_OFF_CTRL)  ? ch2_irq_pkg::SEL_CTRL  :
                 (paddr == `CH2_OFF_MODE)  ? ch2_irq_pkg::SEL_MODE  :
                 (paddr == `CH2_OFF_ODR)   ? ch2_irq_pkg::SEL_ODR   :
                 (paddr == `CH2_OFF_FLAG)  ? ch2_irq_pkg::SEL_FLAG  :
                 (paddr == `CH2_OFF_ISTAT) ? ch2_irq_pkg::SEL_ISTAT :
                 (paddr == `CH2_OFF_IMASK) ? ch2_irq_pkg::SEL_IMASK :
                                             ch2_irq_pkg::SEL_NONE;

    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign wr_access    = access_phase && pwrite;
    assign rd_access    = access_phase && !pwrite;
    assign unmapped     = (sel == ch2_irq_pkg::SEL_NONE);

    // The enables sit only behind the slave CPU bus; no host path exists
    assign ctrl_wr  = wr_access && (sel == ch2_irq_pkg::SEL_CTRL);
    assign ctrl_rd  = rd_access && (sel == ch2_irq_pkg::SEL_CTRL);
    assign mode_wr  = wr_access && (sel == ch2_irq_pkg::SEL_MODE);
    assign odr_wr   = wr_access && (sel == ch2_irq_pkg::SEL_ODR);
    assign istat_wr = wr_access && (sel == ch2_irq_pkg::SEL_ISTAT);
    assign imask_wr = wr_access && (sel == ch2_irq_pkg::SEL_IMASK);

    // Zero wait states; errors only on unmapped addresses
    assign pready  = 1'b1;
    assign pslverr = pslverr_ff && access_phase;
    assign prdata  = prdata_ff;

    // Full flag: the output data write wins over a host take
    assign nxt_obf  = odr_wr ? 1'b1 : (host_obf_clear ? 1'b0 : obf_ff);
    assign obf_fall = obf_ff && !nxt_obf;

    // Hardware clearing of the enables
    assign lpc_reset   = lpc_hw_reset || lpc_sw_reset;
    assign en_hw_clear = lpc_reset || (obf_fall && !ch2_direct_mode_ff);

    // Enable bits, each with its own read-then-write arming
    genvar g;
    generate
        for (g = 0; g < NUM_EN; g++)
        begin : g_en
            host_enable_cell u_cell (
                .pclk      (pclk),
                .presetn   (presetn),
                .rd_strobe (ctrl_rd),
                .rd_value  (prdata_ff[g]),
                .wr_strobe (ctrl_wr),
                .wr_value  (pwdata[g]),
                .hw_clear  (en_hw_clear),
                .enable    (en[g]),
                .armed     (armed[g])
            );
            // Qualified or direct request per line
            assign req[g] = en[g] && (ch2_direct_mode_ff || obf_ff);
        end
    endgenerate

    assign host_line_eleven_request = req_ff[`CH2_BIT_LINE11];
    assign host_line_ten_request    = req_ff[`CH2_BIT_LINE10];
    assign host_line_nine_request   = req_ff[`CH2_BIT_LINE9];
    assign host_line_six_request    = req_ff[`CH2_BIT_LINE6];
    assign ch2_outbuf_full_flag     = obf_ff;

    // Sticky events: set wins over a write-one clear
    assign events[`CH2_EV_OBF_SET] = odr_wr && !obf_ff;
    assign events[`CH2_EV_OBF_CLR] = obf_fall;
    assign nxt_istat = events | (istat_ff & ~(istat_wr ? pwdata[NUM_EV-1:0] : {NUM_EV{1'b0}}));
    assign irq       = |(istat_ff & imask_ff);

    // Read data chosen at setup, presented through the access phase
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (sel)
            ch2_irq_pkg::SEL_CTRL:  rd_mux[NUM_EN-1:0] = en;
            ch2_irq_pkg::SEL_MODE:  rd_mux[`CH2_BIT_DIRECT] = ch2_direct_mode_ff;
            ch2_irq_pkg::SEL_ODR:   rd_mux[7:0] = ch2_output_data_reg_ff;
            ch2_irq_pkg::SEL_FLAG:  rd_mux[`CH2_BIT_OBF] = obf_ff;
            ch2_irq_pkg::SEL_ISTAT: rd_mux[NUM_EV-1:0] = istat_ff;
            ch2_irq_pkg::SEL_IMASK: rd_mux[NUM_EV-1:0] = imask_ff;
            default:                rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_ff <= unmapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ch2_direct_mode_ff     <= `CH2_RST_MODE;
            ch2_output_data_reg_ff <= `CH2_RST_ODR;
            obf_ff                 <= 1'b0;
        end
        else
        begin
            if (mode_wr)
                ch2_direct_mode_ff <= pwdata[`CH2_BIT_DIRECT];
            if (odr_wr)
                ch2_output_data_reg_ff <= pwdata[7:0];
            obf_ff <= nxt_obf;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            istat_ff <= `CH2_RST_ISTAT;
            imask_ff <= `CH2_RST_IMASK;
            req_ff   <= `CH2_RST_ENABLE;
        end
        else
        begin
            istat_ff <= nxt_istat;
            if (imask_wr)
                imask_ff <= pwdata[NUM_EV-1:0];
            req_ff <= req;
        end
    end

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_line11_req;
        (en[`CH2_BIT_LINE11] && obf_ff) |=> host_line_eleven_request;
    endproperty
    a_line11_req: assert property (p_line11_req)
        else $error("line eleven request missing");

    property p_line10_req;
        !(en[`CH2_BIT_LINE10] || ch2_direct_mode_ff) |=> !host_line_ten_request;
    endproperty
    a_line10_req: assert property (p_line10_req)
        else $error("line ten request without enable");

    property p_line9_req;
        (en[`CH2_BIT_LINE9] && !obf_ff && !ch2_direct_mode_ff) |=> !host_line_nine_request;
    endproperty
    a_line9_req: assert property (p_line9_req)
        else $error("line nine request without full flag");

    property p_line6_req;
        $rose(en[`CH2_BIT_LINE6]) && obf_ff ##1 obf_ff |-> host_line_six_request;
    endproperty
    a_line6_req: assert property (p_line6_req)
        else $error("line six request late");

    property p_odr_sets_obf;
        odr_wr |=> ch2_outbuf_full_flag && (ch2_output_data_reg_ff == $past(pwdata[7:0]));
    endproperty
    a_odr_sets_obf: assert property (p_odr_sets_obf)
        else $error("output data write did not set full flag");

    property p_write_zero;
        (ctrl_wr && !pwdata[`CH2_BIT_LINE11]) |=> !en[`CH2_BIT_LINE11];
    endproperty
    a_write_zero: assert property (p_write_zero)
        else $error("write of zero left enable set");

    property p_lpc_reset;
        lpc_reset |=> (en == '0) ##1 (host_line_six_request == 1'b0);
    endproperty
    a_lpc_reset: assert property (p_lpc_reset)
        else $error("lpc reset did not clear enables");

    property p_obf_clear;
        (obf_fall && !ch2_direct_mode_ff) |=> (en == '0) && !ch2_outbuf_full_flag;
    endproperty
    a_obf_clear: assert property (p_obf_clear)
        else $error("flag clear left enables set");

    property p_qualified_req;
        (!ch2_direct_mode_ff && $rose(obf_ff) && en[`CH2_BIT_LINE10]) |=> host_line_ten_request;
    endproperty
    a_qualified_req: assert property (p_qualified_req)
        else $error("flag set did not raise request");

    property p_set_after_read;
        $rose(en[`CH2_BIT_LINE9]) |-> $past(ctrl_wr && pwdata[`CH2_BIT_LINE9] && armed[`CH2_BIT_LINE9]);
    endproperty
    a_set_after_read: assert property (p_set_after_read)
        else $error("enable set without read of zero");

    property p_direct_req;
        (ch2_direct_mode_ff && en[`CH2_BIT_LINE6]) |=> host_line_six_request;
    endproperty
    a_direct_req: assert property (p_direct_req)
        else $error("direct mode request missing");

    property p_line11_off;
        !en[`CH2_BIT_LINE11] |=> !host_line_eleven_request;
    endproperty
    a_line11_off: assert property (p_line11_off)
        else $error("line eleven request without enable");

    property p_line10_qual;
        (en[`CH2_BIT_LINE10] && obf_ff) |=> host_line_ten_request;
    endproperty
    a_line10_qual: assert property (p_line10_qual)
        else $error("line ten request missing");

    property p_line9_direct;
        (en[`CH2_BIT_LINE9] && ch2_direct_mode_ff) |=> host_line_nine_request;
    endproperty
    a_line9_direct: assert property (p_line9_direct)
        else $error("line nine direct request missing");

    property p_line6_off;
        (!en[`CH2_BIT_LINE6] || (!obf_ff && !ch2_direct_mode_ff)) |=> !host_line_six_request;
    endproperty
    a_line6_off: assert property (p_line6_off)
        else $error("line six request without cause");

    property p_flag_only_by_write;
        $rose(obf_ff) |-> $past(odr_wr);
    endproperty
    a_flag_only_by_write: assert property (p_flag_only_by_write)
        else $error("full flag set without data write");

    property p_write_zero_all;
        (ctrl_wr && (pwdata[NUM_EN-1:0] == '0)) |=> (en == '0);
    endproperty
    a_write_zero_all: assert property (p_write_zero_all)
        else $error("write of zeros left an enable set");

    property p_sw_reset;
        lpc_sw_reset |=> (en == '0);
    endproperty
    a_sw_reset: assert property (p_sw_reset)
        else $error("software reset did not clear enables");

    property p_arm_from_read;
        $rose(armed[`CH2_BIT_LINE11]) |-> $past(ctrl_rd && !prdata_ff[`CH2_BIT_LINE11]);
    endproperty
    a_arm_from_read: assert property (p_arm_from_read)
        else $error("enable armed without read of zero");

    property p_unarmed_write;
        (ctrl_wr && pwdata[`CH2_BIT_LINE6] && !armed[`CH2_BIT_LINE6] && !en[`CH2_BIT_LINE6]) |=> !en[`CH2_BIT_LINE6];
    endproperty
    a_unarmed_write: assert property (p_unarmed_write)
        else $error("write of one set an unarmed enable");

    property p_direct_keeps;
        (obf_fall && ch2_direct_mode_ff && !lpc_reset && !ctrl_wr) |=> (en == $past(en));
    endproperty
    a_direct_keeps: assert property (p_direct_keeps)
        else $error("flag clear changed enables in direct mode");

    property p_irq_level;
        (istat_ff[`CH2_EV_OBF_SET] && imask_ff[`CH2_EV_OBF_SET]) |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("masked-in event without interrupt");

    c_qualified: cover property (en[`CH2_BIT_LINE11] && !ch2_direct_mode_ff ##1 odr_wr ##1 obf_ff);
    c_direct: cover property (ch2_direct_mode_ff && !obf_ff && host_line_six_request);
    c_arm_set: cover property (ctrl_rd ##[1:4] (ctrl_wr && pwdata[0]) ##1 en[0]);
    c_obf_clear: cover property (obf_fall && !ch2_direct_mode_ff && (en != '0));
endmodule

// ===== ch2_irq_cfg.svh
// Constants for the channel-2 host interrupt enable block
`ifndef CH2_IRQ_CFG_SVH
`define CH2_IRQ_CFG_SVH

`define CH2_ADDR_W        8
`define CH2_OFF_CTRL      8'h00
`define CH2_OFF_MODE      8'h04
`define CH2_OFF_ODR       8'h08
`define CH2_OFF_FLAG      8'h0c
`define CH2_OFF_ISTAT     8'h10
`define CH2_OFF_IMASK     8'h14

`define CH2_BIT_LINE6     0
`define CH2_BIT_LINE9     1
`define CH2_BIT_LINE10    2
`define CH2_BIT_LINE11    3
`define CH2_BIT_DIRECT    0
`define CH2_BIT_OBF       0
`define CH2_EV_OBF_SET    0
`define CH2_EV_OBF_CLR    1

`define CH2_RST_ENABLE    4'h0
`define CH2_RST_MODE      1'b0
`define CH2_RST_ODR       8'h00
`define CH2_RST_ISTAT     2'h0
`define CH2_RST_IMASK     2'h0

`endif

// ===== ch2_irq_pkg.sv
// Types shared by the channel-2 host interrupt enable block
package ch2_irq_pkg;

    typedef enum logic [2:0] {
        SEL_CTRL  = 3'b000,
        SEL_MODE  = 3'b001,
        SEL_ODR   = 3'b010,
        SEL_FLAG  = 3'b011,
        SEL_ISTAT = 3'b100,
        SEL_IMASK = 3'b101,
        SEL_NONE  = 3'b111
    } reg_sel_t;

endpackage

// ===== host_enable_cell.sv
// One host interrupt enable bit with read-zero-then-write-one arming
`timescale 1ns/1ns
module host_enable_cell (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic rd_strobe,
    input  wire logic rd_value,
    input  wire logic wr_strobe,
    input  wire logic wr_value,
    input  wire logic hw_clear,
    output logic      enable,
    output logic      armed
);
    logic enable_ff;
    logic armed_ff;
    logic nxt_enable;
    logic nxt_armed;

    // Clearing conditions win over a write of one
    always_comb
    begin
        nxt_enable = enable_ff;
        nxt_armed  = armed_ff;
        if (hw_clear)
        begin
            nxt_enable = 1'b0;
            nxt_armed  = 1'b0;
        end
        else if (wr_strobe)
        begin
            nxt_armed = 1'b0;
            if (!wr_value)
                nxt_enable = 1'b0;
            else if (armed_ff)
                nxt_enable = 1'b1;
        end
        else if (rd_strobe && !rd_value)
            nxt_armed = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_ff <= 1'b0;
            armed_ff  <= 1'b0;
        end
        else
        begin
            enable_ff <= nxt_enable;
            armed_ff  <= nxt_armed;
        end
    end

    assign enable = enable_ff;
    assign armed  = armed_ff;
endmodule

// ===== lpc_host_model.sv
// Behavioural LPC host side: takes channel-2 data and issues LPC resets
`timescale 1ns/1ns
module lpc_host_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       take,
    input  wire logic [3:0] dly,
    input  wire logic       hw_cmd,
    input  wire logic       sw_cmd,
    input  wire logic       ch2_outbuf_full_flag,
    output logic            host_obf_clear,
    output logic            lpc_hw_reset,
    output logic            lpc_sw_reset
);
    logic [3:0] wait_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {host_obf_clear, lpc_hw_reset, lpc_sw_reset} <= 3'h0;
            wait_ff <= 4'h0;
        end
        else
        begin
            lpc_hw_reset <= hw_cmd;
            lpc_sw_reset <= sw_cmd;
            host_obf_clear <= 1'b0;
            wait_ff <= 4'h0;
            // Host takes the data dly cycles after take is seen high with the full flag set
            if (take && ch2_outbuf_full_flag && !host_obf_clear)
            begin
                if (wait_ff == dly)
                    host_obf_clear <= 1'b1;
                else
                    wait_ff <= wait_ff + 4'h1;
            end
        end
    end
endmodule

// ===== tb_lpc_ch2_host_irq_enable.sv
// Self-checking bench for the channel-2 host interrupt enables
`timescale 1ns/1ns
`include "ch2_irq_cfg.svh"
module tb_lpc_ch2_host_irq_enable;
    logic        pclk, presetn, psel, penable, pwrite, take, hw_cmd, sw_cmd, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd, wdat;
    logic [3:0]  dly, v;
    wire  [31:0] prdata;
    wire         pready, pslverr, obf_clr, hw_rst, sw_rst, flag, irq;
    wire  [3:0]  req;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles = 0;

    ch2_host_irq_enable i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_obf_clear(obf_clr), .lpc_hw_reset(hw_rst), .lpc_sw_reset(sw_rst),
        .host_line_eleven_request(req[3]), .host_line_ten_request(req[2]),
        .host_line_nine_request(req[1]), .host_line_six_request(req[0]),
        .ch2_outbuf_full_flag(flag), .irq(irq));

    lpc_host_model i_host (.pclk(pclk), .presetn(presetn), .take(take), .dly(dly), .hw_cmd(hw_cmd),
        .sw_cmd(sw_cmd), .ch2_outbuf_full_flag(flag), .host_obf_clear(obf_clr),
        .lpc_hw_reset(hw_rst), .lpc_sw_reset(sw_rst));

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_line(input logic [3:0] got, input logic [3:0] exp);
        chk_word({28'h0, got}, {28'h0, exp});
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    function automatic logic [3:0] exp_req(input logic [3:0] en, input logic d, input logic f);
        return en & {4{d | f}};
    endfunction

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait states end only at pready; the bench timeout bounds a hang
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic set_en(input logic [3:0] e);
        apb(1'b0, `CH2_OFF_CTRL, 32'h0);
        apb(1'b1, `CH2_OFF_CTRL, {28'h0, e});
    endtask

    task automatic take_flag();
        take <= 1'b1;
        do
            @(posedge pclk);
        while (flag !== 1'b0);
        take <= 1'b0;
        @(posedge pclk);
    endtask

    initial
    begin
        {psel, penable, pwrite, take, hw_cmd, sw_cmd} = 6'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        dly = 4'h0;
        presetn = 1'b0;
        v = 4'($urandom(55065));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `CH2_OFF_CTRL, 32'h0);
        chk_word(rd, 32'h0);
        apb(1'b1, `CH2_OFF_CTRL, 32'h0);
        apb(1'b1, `CH2_OFF_CTRL, 32'hf);
        apb(1'b0, `CH2_OFF_CTRL, 32'h0);
        chk_word(rd, 32'h0);
        $display("test reset_and_arming done");
        repeat (8)
        begin
            v = 4'($urandom);
            dly = 4'($urandom);
            set_en(v);
            apb(1'b0, `CH2_OFF_CTRL, 32'h0);
            chk_word(rd, {28'h0, v});
            chk_line(req, 4'h0);
            wdat = {24'h0, 8'($urandom)};
            apb(1'b1, `CH2_OFF_ODR, wdat);
            @(posedge pclk);
            chk_flag(flag, 1'b1);
            chk_line(req, exp_req(v, 1'b0, 1'b1));
            apb(1'b0, `CH2_OFF_ODR, 32'h0);
            chk_word(rd, wdat);
            apb(1'b0, `CH2_OFF_FLAG, 32'h0);
            chk_word(rd, 32'h1);
            take_flag();
            chk_line(req, 4'h0);
            apb(1'b0, `CH2_OFF_CTRL, 32'h0);
            chk_word(rd, 32'h0);
        end
        $display("test qualified_mode done");
        apb(1'b1, `CH2_OFF_MODE, 32'h1);
        apb(1'b0, `CH2_OFF_MODE, 32'h0);
        chk_word(rd, 32'h1);
        set_en(4'ha);
        @(posedge pclk);
        chk_line(req, exp_req(4'ha, 1'b1, 1'b0));
        apb(1'b1, `CH2_OFF_ODR, 32'h3c);
        take_flag();
        apb(1'b0, `CH2_OFF_CTRL, 32'h0);
        chk_word(rd, 32'ha);
        apb(1'b1, `CH2_OFF_CTRL, 32'h2);
        apb(1'b0, `CH2_OFF_CTRL, 32'h0);
        chk_word(rd, 32'h2);
        for (int i = 0; i < 2; i++)
        begin
            set_en(4'hf);
            hw_cmd <= (i == 0);
            sw_cmd <= (i == 1);
            @(posedge pclk);
            hw_cmd <= 1'b0;
            sw_cmd <= 1'b0;
            // Pulse crosses the host model, then the enables, then the request register
            repeat (3) @(posedge pclk);
            chk_line(req, 4'h0);
            apb(1'b0, `CH2_OFF_CTRL, 32'h0);
            chk_word(rd, 32'h0);
        end
        $display("test direct_and_resets done");
        apb(1'b1, `CH2_OFF_MODE, 32'h0);
        apb(1'b1, `CH2_OFF_ISTAT, 32'h3);
        apb(1'b1, `CH2_OFF_IMASK, 32'h1);
        apb(1'b1, `CH2_OFF_ODR, 32'h5a);
        chk_flag(irq, 1'b1);
        apb(1'b1, `CH2_OFF_IMASK, 32'h2);
        chk_flag(irq, 1'b0);
        take_flag();
        chk_flag(irq, 1'b1);
        apb(1'b1, `CH2_OFF_ISTAT, 32'h2);
        chk_flag(irq, 1'b0);
        apb(1'b0, `CH2_OFF_ISTAT, 32'h0);
        chk_word(rd, 32'h1);
        chk_flag(err, 1'b0);
        apb(1'b0, 8'h3c, 32'h0);
        chk_word(rd, 32'h0);
        chk_flag(err, 1'b1);
        $display("test interrupt_and_unmapped done");
        complete_run();
    end
endmodule
